//--- common/lhi_defs.vh
// Constants for the host interrupt request block: register offsets, field positions, reset values and timing.
// Assumes a 32-bit AHB-Lite register window decoded on haddr[7:0] and a 16-bit host I/O address space.
`ifndef LHI_DEFS_VH
`define LHI_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define LHI_OFS_CTRL        8'h00
`define LHI_OFS_ENABLE      8'h04
`define LHI_OFS_OUT_CH1     8'h08
`define LHI_OFS_OUT_CH2     8'h0c
`define LHI_OFS_OUT_CH3     8'h10
`define LHI_OFS_BIDIR_LAST  8'h14
`define LHI_OFS_STATUS      8'h18
`define LHI_OFS_CH3_BASE    8'h1c
`define LHI_OFS_BIDIR_FIRST 8'h20
`define LHI_OFS_IN_CH3      8'h24

// ****************************************
// Field positions
// ****************************************
`define LHI_CTRL_DIRECT     0
`define LHI_CTRL_RUN        1
`define LHI_CTRL_QUIET      2
`define LHI_EN_BITS         13
`define LHI_ST_IN_FULL      4
`define LHI_ST_HOST_MARK    5
`define LHI_ST_SLAVE_MARK   6
`define LHI_ST_REQ_LSB      8

// ****************************************
// Reset value and default host addresses
// ****************************************
`define LHI_CH3_BASE_RST    16'ha24f
`define LHI_CH1_HOST_ADDR   16'h0060
`define LHI_CH2_HOST_ADDR   16'h0062

// ****************************************
// Serial interrupt frame numbers and timing
// ****************************************
`define LHI_FRM_REQ1        5'h02
`define LHI_FRM_MGMT        5'h03
`define LHI_FRM_REQ6        5'h07
`define LHI_FRM_REQ9        5'h0a
`define LHI_FRM_REQ10       5'h0b
`define LHI_FRM_REQ11       5'h0c
`define LHI_FRM_REQ12       5'h0d
`define LHI_FRM_LAST        5'h11
`define LHI_STOP_QUIET      3'h2
`define LHI_SYNC_STAGES     2

`endif

//--- hdl/lhi_sync.v
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes every bit is a level that is stable for many clk cycles around its change.
`timescale 1ns/1ps
module lhi_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // lhi_sync

//--- hdl/lhi_irq_top.v
// Host interrupt request logic of an LPC slave host interface, with AHB-Lite register slave and serial
// interrupt slot driver. Assumes host accesses arrive as levels sampled on rising edges of lclk.
//
// Contract
// - Seven host interrupt requests exist, each sent on the serial interrupt line.
// - Requests 1 and 12 come from channel 1; others from channels 2 or 3.
// - Mode 0: host read clearing output-full also clears the matching enable bit.
// - Mode 1: channel 2/3 requests follow only enable bits, untouched by host reads.
// - Mode 1: firmware withdraws channel 2/3 requests only by writing enable 0.
// - Request 1 sets after channel 1 data write, enable read 0, write 1.
// - Request 1 clears on enable write 0 or host read of channel 1 data.
// - Request 12 sets and clears like request 1 using its own enable.
// - Mode 0: management request armed by three data sources, cleared by 0-write or read.
// - Mode 1: management enables set by read 0 then write 1, no data write.
// - Mode 0: requests 6, 9, 10, 11 armed per channel by data write and enable.
// - Mode 1: requests 6, 9, 10, 11 set by read 0 write 1, cleared by 0.
// - After reset the interface is stopped; registers other than CTRL work only once started.
// - Full flags only report buffer state; neither side's reads or writes of the buffers are blocked by them.
// - Write markers show which side owns the bidirectional registers after first write.
// - Base A24F decodes data A24A/A24E, status A24E, bidirectional from A250.
// - Base 3FD0 decodes data 3FD0/3FD4, status 3FD4, bidirectional from 3FC0.
// - In quiet mode a new request drives clock-run to restart the link clock.
// - Each active request is driven in its own serial interrupt frame slot.
`timescale 1ns/1ps
`include "lhi_defs.vh"
module lhi_irq_top
#(
  parameter [15:0] CH1_ADDR = `LHI_CH1_HOST_ADDR,
  parameter [15:0] CH2_ADDR = `LHI_CH2_HOST_ADDR
)
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  input  wire        lclk,
  input  wire        lpc_rd,
  input  wire        lpc_wr,
  input  wire [15:0] lpc_addr,
  input  wire [7:0]  lpc_wdata,
  output reg  [7:0]  lpc_rdata_q,
  input  wire        serirq_i,
  output reg         serirq_o,
  output reg         serirq_oe,
  output wire        clkrun_n_o,
  output reg         clkrun_oe,
  output wire [6:0]  host_req
);

  // ****************************************
  // Pin synchronisers and link edge detect
  // ****************************************
  wire [27:0] pin_s;
  reg         lclk_d_q;
  lhi_sync #(.W(28)) u_sync
  (
    .clk  (clk),
    .rstn (rstn),
    .din  ({lclk, serirq_i, lpc_rd, lpc_wr, lpc_addr, lpc_wdata}),
    .dout (pin_s)
  );
  wire        lclk_s  = pin_s[27];
  wire        sirq_s  = pin_s[26];
  wire        h_rd_s  = pin_s[25];
  wire        h_wr_s  = pin_s[24];
  wire [15:0] h_addr  = pin_s[23:8];
  wire [7:0]  h_wdata = pin_s[7:0];

  always @(posedge clk)
  begin
    if (!rstn)
      lclk_d_q <= 1'b0;
    else
      lclk_d_q <= lclk_s;
  end
  wire lrise = lclk_s & ~lclk_d_q;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  reg        run_q;
  reg        direct_q;
  reg        quiet_q;
  reg [15:0] base3_q;
  reg [12:0] en_q;
  reg [12:0] read0_q;
  reg [12:0] arm_q;
  reg [7:0]  out1_q;
  reg [7:0]  out2_q;
  reg [7:0]  out3_q;
  reg [7:0]  blast_q;
  reg [7:0]  in3_q;
  reg [3:0]  ofull_q;
  reg        ifull_q;
  reg        hmark_q;
  reg        smark_q;
  reg        wpend_q;
  reg [7:0]  waddr_q;

  // Zero-wait slave: every transfer completes in its first data phase, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire       acc   = hsel & hready & htrans[1];
  wire       a_rd  = acc & ~hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  // Stopped interface answers every register but CTRL as zero and ignores writes
  wire       w_ctl = wpend_q & (waddr_q == `LHI_OFS_CTRL);
  wire       w_any = wpend_q & run_q;
  wire       w_en  = w_any & (waddr_q == `LHI_OFS_ENABLE);
  wire       r_en  = a_rd & run_q & (a_ofs == `LHI_OFS_ENABLE);
  wire       r_in  = a_rd & run_q & (a_ofs == `LHI_OFS_IN_CH3);
  wire [3:0] cpu_dw;
  assign cpu_dw[0] = w_any & (waddr_q == `LHI_OFS_OUT_CH1);
  assign cpu_dw[1] = w_any & (waddr_q == `LHI_OFS_OUT_CH2);
  assign cpu_dw[2] = w_any & (waddr_q == `LHI_OFS_OUT_CH3);
  assign cpu_dw[3] = w_any & (waddr_q == `LHI_OFS_BIDIR_LAST);
  wire       cpu_bf = w_any & (waddr_q == `LHI_OFS_BIDIR_FIRST);

  wire [31:0] status_w = {17'h00000, host_req, 1'b0, smark_q, hmark_q, ifull_q, ofull_q};
  reg  [31:0] rd_val;
  always @*
  begin
    rd_val = 32'h00000000;
    if (a_ofs == `LHI_OFS_CTRL)
      rd_val = {29'h00000000, quiet_q, run_q, direct_q};
    else if (run_q)
    begin
      case (a_ofs)
        `LHI_OFS_ENABLE:     rd_val = {19'h00000, en_q};
        `LHI_OFS_OUT_CH1:    rd_val = {24'h000000, out1_q};
        `LHI_OFS_OUT_CH2:    rd_val = {24'h000000, out2_q};
        `LHI_OFS_OUT_CH3:    rd_val = {24'h000000, out3_q};
        `LHI_OFS_BIDIR_LAST: rd_val = {24'h000000, blast_q};
        `LHI_OFS_STATUS:     rd_val = status_w;
        `LHI_OFS_CH3_BASE:   rd_val = {16'h0000, base3_q};
        `LHI_OFS_IN_CH3:     rd_val = {24'h000000, in3_q};
        default:             rd_val = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wpend_q  <= 1'b0;
      waddr_q  <= 8'h00;
      hrdata   <= 32'h00000000;
      run_q    <= 1'b0;
      direct_q <= 1'b0;
      base3_q  <= `LHI_CH3_BASE_RST;
      out1_q   <= 8'h00;
      out2_q   <= 8'h00;
      out3_q   <= 8'h00;
      blast_q  <= 8'h00;
    end
    else
    begin
      wpend_q <= acc & hwrite;
      waddr_q <= a_ofs;
      if (a_rd)
        hrdata <= rd_val;
      if (w_ctl)
      begin
        run_q    <= hwdata[`LHI_CTRL_RUN];
        direct_q <= hwdata[`LHI_CTRL_DIRECT];
      end
      if (w_any & (waddr_q == `LHI_OFS_CH3_BASE))
        base3_q <= hwdata[15:0];
      if (cpu_dw[0])
        out1_q <= hwdata[7:0];
      if (cpu_dw[1])
        out2_q <= hwdata[7:0];
      if (cpu_dw[2])
        out3_q <= hwdata[7:0];
      if (cpu_dw[3])
        blast_q <= hwdata[7:0];
    end
  end

  // ****************************************
  // Host side address decode
  // ****************************************
  // Channel 3 data sits at base with bits 2 and 0 cleared, status with bit 2 set,
  // and the sixteen bidirectional registers in the block with base bit 4 inverted.
  wire [15:0] ch3_data = {base3_q[15:3], 1'b0, base3_q[1], 1'b0};
  wire [15:0] ch3_stat = {base3_q[15:3], 1'b1, base3_q[1], 1'b0};
  wire        in_bidir = (h_addr[15:4] == {base3_q[15:5], ~base3_q[4]});
  wire        h_rd     = lrise & h_rd_s & run_q;
  wire        h_wr     = lrise & h_wr_s & run_q;
  wire [3:0]  host_rs;
  assign host_rs[0] = h_rd & (h_addr == CH1_ADDR);
  assign host_rs[1] = h_rd & (h_addr == CH2_ADDR);
  assign host_rs[2] = h_rd & (h_addr == ch3_data);
  assign host_rs[3] = h_rd & in_bidir & (h_addr[3:0] == 4'hf);
  wire        h_in3    = h_wr & ((h_addr == ch3_data) | (h_addr == ch3_stat));
  wire        h_bfirst = h_wr & in_bidir & (h_addr[3:0] == 4'h0);
  wire        h_blast  = h_wr & in_bidir & (h_addr[3:0] == 4'hf);

  always @(posedge clk)
  begin
    if (!rstn)
      lpc_rdata_q <= 8'h00;
    else if (h_rd)
    begin
      if (host_rs[0])
        lpc_rdata_q <= out1_q;
      else if (host_rs[1])
        lpc_rdata_q <= out2_q;
      else if (host_rs[2])
        lpc_rdata_q <= out3_q;
      else if (h_addr == ch3_stat)
        lpc_rdata_q <= status_w[7:0];
      else if (host_rs[3])
        lpc_rdata_q <= blast_q;
      else
        lpc_rdata_q <= 8'h00;
    end
  end

  // ****************************************
  // Buffer flags and write markers
  // ****************************************
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ofull_q <= 4'h0;
      ifull_q <= 1'b0;
      in3_q   <= 8'h00;
      hmark_q <= 1'b0;
      smark_q <= 1'b0;
    end
    else
    begin
      // A CPU write in the same cycle as the host read keeps the flag set
      ofull_q <= cpu_dw | (ofull_q & ~host_rs);
      if (h_in3)
        in3_q <= h_wdata;
      ifull_q <= h_in3 | (ifull_q & ~r_in);
      // Ownership is granted only to the side that finds the other marker clear
      if (h_bfirst & ~smark_q)
        hmark_q <= 1'b1;
      else if (h_blast)
        hmark_q <= 1'b0;
      if (cpu_bf & ~hmark_q)
        smark_q <= 1'b1;
      else if (cpu_dw[3])
        smark_q <= 1'b0;
    end
  end

  // ****************************************
  // Enable bits
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LHI_EN_BITS; gi = gi + 1)
    begin : g_en
      // Bits 0-1 channel 1, 2 ch2, 3 ch3 out, 4 ch3 bidir, 5-8 ch2 (6,9,10,11), 9-12 ch3 (6,9,10,11)
      localparam integer SRC = (gi < 2) ? 0 : (gi == 2) ? 1 : (gi == 3) ? 2 : (gi == 4) ? 3 : (gi < 9) ? 1 : 2;
      wire dir_ok = direct_q & (SRC != 0);
      wire set_b  = w_en & hwdata[gi] & read0_q[gi] & (arm_q[gi] | dir_ok);
      wire clr_b  = (w_en & ~hwdata[gi]) | (host_rs[SRC] & ~dir_ok);
      always @(posedge clk)
      begin
        if (!rstn)
        begin
          en_q[gi]    <= 1'b0;
          read0_q[gi] <= 1'b0;
          arm_q[gi]   <= 1'b0;
        end
        else
        begin
          if (set_b)
            en_q[gi] <= 1'b1;
          else if (clr_b)
            en_q[gi] <= 1'b0;
          if (r_en & ~en_q[gi])
            read0_q[gi] <= 1'b1;
          else if (w_en)
            read0_q[gi] <= 1'b0;
          if (cpu_dw[SRC])
            arm_q[gi] <= 1'b1;
          else if (w_en | host_rs[SRC])
            arm_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Order: 1, management, 6, 9, 10, 11, 12
  assign host_req = {en_q[1], en_q[8] | en_q[12], en_q[7] | en_q[11], en_q[6] | en_q[10],
                     en_q[5] | en_q[9], en_q[2] | en_q[3] | en_q[4], en_q[0]};

  // ****************************************
  // Serial interrupt slot driver
  // ****************************************
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_START = 2'd1;
  localparam [1:0] S_FRM = 2'd2;
  localparam [1:0] S_STOP = 2'd3;
  reg [1:0] st_q;
  reg [4:0] frm_q;
  reg [1:0] ph_q;
  reg [2:0] low_q;
  reg [6:0] snap_q;
  reg       drove_q;
  reg       seen_q;

  // Snapshot keeps each slot's value steady for the whole cycle
  wire req_here = (frm_q == `LHI_FRM_REQ1 && snap_q[0]) || (frm_q == `LHI_FRM_MGMT && snap_q[1]) ||
                  (frm_q == `LHI_FRM_REQ6 && snap_q[2]) || (frm_q == `LHI_FRM_REQ9 && snap_q[3]) ||
                  (frm_q == `LHI_FRM_REQ10 && snap_q[4]) || (frm_q == `LHI_FRM_REQ11 && snap_q[5]) ||
                  (frm_q == `LHI_FRM_REQ12 && snap_q[6]);
  // Slot test for the frame about to start
  wire [4:0] frm_n = frm_q + 5'h01;
  wire req_here_next = (frm_n == `LHI_FRM_REQ1 && snap_q[0]) || (frm_n == `LHI_FRM_MGMT && snap_q[1]) ||
                       (frm_n == `LHI_FRM_REQ6 && snap_q[2]) || (frm_n == `LHI_FRM_REQ9 && snap_q[3]) ||
                       (frm_n == `LHI_FRM_REQ10 && snap_q[4]) || (frm_n == `LHI_FRM_REQ11 && snap_q[5]) ||
                       (frm_n == `LHI_FRM_REQ12 && snap_q[6]);
  wire want = run_q & quiet_q & (|host_req);
  assign clkrun_n_o = 1'b0;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q      <= S_IDLE;
      frm_q     <= 5'h00;
      ph_q      <= 2'd0;
      low_q     <= 3'h0;
      snap_q    <= 7'h00;
      drove_q   <= 1'b0;
      seen_q    <= 1'b0;
      quiet_q   <= 1'b0;
      serirq_o  <= 1'b1;
      serirq_oe <= 1'b0;
      clkrun_oe <= 1'b0;
    end
    else
    begin
      // Link clock may be stopped in quiet mode: ask for it until an edge arrives
      clkrun_oe <= want & (st_q == S_IDLE) & ~seen_q & ~lrise;
      if (st_q != S_IDLE || !want)
        seen_q <= 1'b0;
      else if (lrise)
        seen_q <= 1'b1;
      if (lrise)
      begin
        case (st_q)
          S_IDLE:
          begin
            serirq_oe <= 1'b0;
            serirq_o  <= 1'b1;
            if (!sirq_s)
            begin
              st_q   <= S_START;
              snap_q <= host_req;
            end
            else if (want & seen_q)
            begin
              serirq_o  <= 1'b0;
              serirq_oe <= 1'b1;
            end
          end
          S_START:
          begin
            serirq_oe <= 1'b0;
            serirq_o  <= 1'b1;
            if (sirq_s)
            begin
              st_q  <= S_FRM;
              frm_q <= 5'h00;
              ph_q  <= 2'd1;
            end
          end
          S_FRM:
          begin
            // Phase 0 drives low, phase 1 recovers high, phase 2 turns around
            if (ph_q == 2'd2)
            begin
              ph_q  <= 2'd0;
              frm_q <= frm_q + 5'h01;
              if (frm_q == `LHI_FRM_LAST)
              begin
                st_q  <= S_STOP;
                low_q <= 3'h0;
              end
              else if (req_here_next)
              begin
                serirq_o  <= 1'b0;
                serirq_oe <= 1'b1;
                drove_q   <= 1'b1;
              end
            end
            else if (ph_q == 2'd0)
            begin
              ph_q     <= 2'd1;
              serirq_o <= 1'b1;
              serirq_oe <= drove_q;
            end
            else
            begin
              ph_q      <= 2'd2;
              serirq_oe <= 1'b0;
              drove_q   <= 1'b0;
            end
          end
          S_STOP:
          begin
            if (!sirq_s)
              low_q <= low_q + 3'h1;
            else if (low_q != 3'h0)
            begin
              quiet_q <= (low_q == `LHI_STOP_QUIET);
              st_q    <= S_IDLE;
            end
          end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

  wire unused_ok = req_here | hsize[0] | (|haddr[31:8]);

endmodule // lhi_irq_top

//--- testbench/lhi_irq_properties.sv
// Concurrent checks on the ports of the host interrupt request block.
// Assumes AHB-Lite writes land at the edge that ends the data phase.
`timescale 1ns/1ps
`include "lhi_defs.vh"
module lhi_irq_properties (
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        lpc_rd,
  input wire [7:0]  lpc_rdata_q,
  input wire        serirq_o,
  input wire        serirq_oe,
  input wire        clkrun_oe,
  input wire [6:0]  host_req
);
  reg       dp_q, dw_q, ran_q, dir_q, seen_q;
  reg [7:0] da_q;
  reg [4:0] age_q;
  wire      en_wr = dp_q && dw_q && da_q == `LHI_OFS_ENABLE;
  wire      ct_wr = dp_q && dw_q && da_q == `LHI_OFS_CTRL;
  function [6:0] emap(input [12:0] e);
    emap = {e[1], e[8] | e[12], e[7] | e[11], e[6] | e[10], e[5] | e[9], e[2] | e[3] | e[4], e[0]};
  endfunction
  // ****************************************
  // Bus and host access tracking
  // ****************************************
  always @(posedge clk)
  begin
    dw_q <= hwrite;
    da_q <= haddr[7:0];
    if (!rstn)
    begin
      dp_q <= 1'b0;
      ran_q <= 1'b0;
      dir_q <= 1'b0;
      seen_q <= 1'b0;
      age_q <= 5'h1f;
    end
    else
    begin
      dp_q <= hsel && hready && htrans[1];
      ran_q <= ran_q | (ct_wr & hwdata[1]);
      dir_q <= ct_wr ? hwdata[0] : dir_q;
      seen_q <= seen_q | (host_req != 7'h0);
      // Saturate so a long quiet spell never wraps back into the window
      age_q <= lpc_rd ? 5'h0 : (age_q == 5'h1f ? age_q : age_q + 5'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_held_reset;
    !rstn [*2];
  endsequence
  chk_reset_quiet:
    assert property (disable iff (1'b0) s_held_reset |-> host_req == 7'h0 && !serirq_oe && !clkrun_oe
      && lpc_rdata_q == 8'h00) else $error("outputs not cleared in reset");
  chk_stop_silent:
    assert property (!ran_q |-> host_req == 7'h0) else $error("request while stopped");
  chk_req_rise:
    assert property ((host_req & ~$past(host_req)) != 7'h0 |-> $past(en_wr)
      && (host_req & ~$past(host_req) & ~emap($past(hwdata[12:0]))) == 7'h0) else $error("bad request rise");
  chk_req_fall:
    assert property (($past(host_req) & ~host_req) != 7'h0 |-> $past(en_wr) || age_q < 5'd16)
      else $error("request fell without cause");
  chk_direct_keep:
    assert property (dir_q && $past(dir_q) && ($past(host_req[5:1]) & ~host_req[5:1]) != 5'h0
      |-> $past(en_wr)) else $error("direct mode request cleared by host");
  chk_clkrun_cause:
    assert property ($rose(clkrun_oe) |-> $past(host_req) != 7'h0) else $error("clock run without request");
  chk_slot_cause:
    assert property (serirq_oe && !serirq_o |-> seen_q) else $error("slot driven without request");
  chk_rdata_cause:
    assert property ($changed(lpc_rdata_q) |-> age_q < 5'd16) else $error("host data changed without read");
endmodule // lhi_irq_properties
bind lhi_irq_top lhi_irq_properties u_chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .lpc_rd, .lpc_rdata_q, .serirq_o, .serirq_oe, .clkrun_oe, .host_req);

//--- testbench/lhi_host_model.sv
// Host chipset model: link clock, host I/O cycles and serial interrupt cycles.
// Assumes the line is pulled up when nobody drives it.
`timescale 1ns/1ps
module lhi_host_model (
  input  wire        serirq_o,
  input  wire        serirq_oe,
  input  wire        clkrun_oe,
  input  wire [7:0]  lpc_rdata_q,
  output reg         lclk,
  output reg         lpc_rd,
  output reg         lpc_wr,
  output reg  [15:0] lpc_addr,
  output reg  [7:0]  lpc_wdata,
  output wire        serirq_i,
  output reg  [6:0]  seen
);
  reg     park, hoe, ho;
  integer s;
  assign serirq_i = serirq_oe ? serirq_o : (hoe ? ho : 1'b1);
  function [6:0] slot(input integer f);
    slot = f == 2 ? 7'h01 : f == 3 ? 7'h02 : f == 7 ? 7'h04 : f == 13 ? 7'h40 :
      (f > 9 && f < 13) ? 7'h08 << (f - 10) : 7'h00;
  endfunction
  // ****************************************
  // Clock, host cycles, serial cycles
  // ****************************************
  initial
  begin
    {park, hoe, ho, lpc_rd, lpc_wr, lclk} = 6'h08;
    lpc_addr = 16'hffff;
    lpc_wdata = 8'h00;
    seen = 7'h0;
    #3.3;
    // Parked clock stands low until the block asks for it back
    forever
    begin
      #80;
      park = park & ~clkrun_oe;
      lclk = park ? 1'b0 : ~lclk;
    end
  end
  // One access per link clock; the host reads without checking any full flag
  task io(input w, input [15:0] a, input [7:0] d, output [7:0] r);
    begin
      @(negedge lclk);
      lpc_addr <= a;
      lpc_wdata <= d;
      lpc_rd <= !w;
      lpc_wr <= w;
      @(negedge lclk);
      lpc_rd <= 1'b0;
      lpc_wr <= 1'b0;
      lpc_addr <= ~a;
      lpc_wdata <= ~d;
      @(posedge lclk);
      r = lpc_rdata_q;
    end
  endtask
  task ser(input quiet, input slv);
    begin
      seen = 7'h0;
      repeat (slv ? 3 : 4)
      begin
        @(posedge lclk);
        hoe <= 1'b1;
        ho <= 1'b0;
      end
      @(posedge lclk);
      ho <= 1'b1;
      @(posedge lclk);
      hoe <= 1'b0;
      for (s = 0; s < 51; s = s + 1)
      begin
        @(posedge lclk);
        @(negedge lclk);
        if (s % 3 == 0 && serirq_i === 1'b0)
          seen = seen | slot(s / 3 + 1);
      end
      @(posedge lclk);
      repeat (quiet ? 2 : 3)
      begin
        @(posedge lclk);
        hoe <= 1'b1;
        ho <= 1'b0;
      end
      @(posedge lclk);
      ho <= 1'b1;
      @(posedge lclk);
      hoe <= 1'b0;
    end
  endtask
endmodule // lhi_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the host interrupt request block.
// Assumes the host model owns the link clock and the serial interrupt line.
`timescale 1ns/1ps
`include "lhi_defs.vh"
module tb_top;
  reg         clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'ha104, rd;
  reg  [12:0] m;
  reg  [7:0]  db, hb;
  reg  [23:0] sa;
  wire [31:0] hrdata;
  wire [15:0] lpc_addr;
  wire [7:0]  lpc_wdata, lpc_rdata_q;
  wire [6:0]  host_req, seen;
  wire        hreadyout, hresp, lclk, lpc_rd, lpc_wr, serirq_i, serirq_o, serirq_oe, clkrun_n_o, clkrun_oe;
  integer     miscompares = 0, checks_done = 0, i, k;
  always #2 clk = ~clk;
  lhi_irq_top DUT (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .lclk, .lpc_rd, .lpc_wr, .lpc_addr, .lpc_wdata, .lpc_rdata_q, .serirq_i, .serirq_o,
    .serirq_oe, .clkrun_n_o, .clkrun_oe, .host_req);
  lhi_host_model u_host (.serirq_o, .serirq_oe, .clkrun_oe, .lpc_rdata_q, .lclk, .lpc_rd, .lpc_wr, .lpc_addr,
    .lpc_wdata, .serirq_i, .seen);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [6:0] emap(input [12:0] e);
    emap = {e[1], e[8] | e[12], e[7] | e[11], e[6] | e[10], e[5] | e[9], e[2] | e[3] | e[4], e[0]};
  endfunction
  // Source of an enable bit as {bus offset, host address}
  function [23:0] srcof(input integer b);
    srcof = b < 2 ? {`LHI_OFS_OUT_CH1, `LHI_CH1_HOST_ADDR} : b == 4 ? {`LHI_OFS_BIDIR_LAST, 16'ha25f} :
      (b == 3 || b > 8) ? {`LHI_OFS_OUT_CH3, 16'ha24a} : {`LHI_OFS_OUT_CH2, `LHI_CH2_HOST_ADDR};
  endfunction
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task summarize;
    begin
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [127:0] nm, input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        $display("Error %0s expected %h seen %h", nm, exp, got);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task rdy;
    integer n;
    begin
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1)
      begin
        n = n + 1;
        if (n == 64)
        begin
          miscompares = miscompares + 1;
          summarize;
        end
        @(posedge clk);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      rd = hrdata;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      ahb(1'b0, a, 32'h0);
      check("bus read", rd, exp);
    end
  endtask
  task hq(input [6:0] exp);
    begin
      repeat (2) @(posedge clk);
      check("host_req", host_req, exp);
    end
  endtask
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    hq(7'h0);
    ahb(1'b1, `LHI_OFS_CH3_BASE, 32'h3fd0);
    rdc(`LHI_OFS_ENABLE, 32'h0);
    ahb(1'b1, `LHI_OFS_CTRL, 32'h2);
    rdc(`LHI_OFS_CH3_BASE, 32'ha24f);
    rdc(8'h3c, 32'h0);
    // Each bit: refused without read-0, refused without data, then armed and cleared
    for (i = 0; i < 13; i = i + 1)
    begin
      sa = srcof(i);
      ahb(1'b1, `LHI_OFS_ENABLE, 32'h0);
      db = rnd[7:0];
      rnd = lfsr(rnd);
      ahb(1'b1, sa[23:16], db);
      ahb(1'b1, `LHI_OFS_ENABLE, 32'h1 << i);
      hq(7'h0);
      rdc(`LHI_OFS_ENABLE, 32'h0);
      ahb(1'b1, `LHI_OFS_ENABLE, 32'h1 << i);
      hq(7'h0);
      ahb(1'b1, sa[23:16], db);
      rdc(`LHI_OFS_ENABLE, 32'h0);
      ahb(1'b1, `LHI_OFS_ENABLE, 32'h1 << i);
      hq(emap(13'h1 << i));
      if (i % 2)
      begin
        ahb(1'b1, `LHI_OFS_ENABLE, 32'h0);
        hq(7'h0);
      end
      u_host.io(1'b0, sa[15:0], 8'h00, hb);
      check("host data", hb, db);
      hq(7'h0);
      rdc(`LHI_OFS_ENABLE, 32'h0);
    end
    ahb(1'b1, `LHI_OFS_CTRL, 32'h3);
    m = {rnd[12:2], 2'b00} | 13'h0004;
    rnd = lfsr(rnd);
    rdc(`LHI_OFS_ENABLE, 32'h0);
    ahb(1'b1, `LHI_OFS_ENABLE, m);
    hq(emap(m));
    ahb(1'b1, `LHI_OFS_OUT_CH2, db);
    u_host.io(1'b0, `LHI_CH2_HOST_ADDR, 8'h00, hb);
    hq(emap(m));
    rdc(`LHI_OFS_ENABLE, m);
    ahb(1'b1, `LHI_OFS_ENABLE, m | 13'h1);
    hq(emap(m));
    ahb(1'b1, `LHI_OFS_OUT_CH1, db);
    rdc(`LHI_OFS_ENABLE, m);
    ahb(1'b1, `LHI_OFS_ENABLE, m | 13'h1);
    hq(emap(m | 13'h1));
    u_host.ser(1'b0, 1'b0);
    check("serial slots", seen, emap(m | 13'h1));
    ahb(1'b1, `LHI_OFS_ENABLE, 32'h0);
    hq(7'h0);
    ahb(1'b1, `LHI_OFS_CTRL, 32'h2);
    ahb(1'b1, `LHI_OFS_CH3_BASE, 32'h3fd0);
    ahb(1'b1, `LHI_OFS_OUT_CH3, db);
    u_host.io(1'b0, 16'h3fd4, 8'h00, hb);
    check("status out full", hb[2], 1'b1);
    u_host.io(1'b0, 16'h3fd0, 8'h00, hb);
    check("ch3 out data", hb, db);
    for (i = 0; i < 2; i = i + 1)
    begin
      u_host.io(1'b1, 16'h3fd0 + 16'h4 * i, db ^ i, hb);
      ahb(1'b0, `LHI_OFS_STATUS, 32'h0);
      check("input full", rd[4], 1'b1);
      rdc(`LHI_OFS_IN_CH3, db ^ i);
      ahb(1'b0, `LHI_OFS_STATUS, 32'h0);
      check("input empty", rd[4], 1'b0);
    end
    u_host.io(1'b1, 16'h3fc0, 8'h11, hb);
    ahb(1'b1, `LHI_OFS_BIDIR_FIRST, 32'h22);
    ahb(1'b0, `LHI_OFS_STATUS, 32'h0);
    check("write markers", rd[6:5], 2'b01);
    u_host.ser(1'b1, 1'b0);
    u_host.park = 1'b1;
    ahb(1'b1, `LHI_OFS_OUT_CH1, db);
    rdc(`LHI_OFS_ENABLE, 32'h0);
    ahb(1'b1, `LHI_OFS_ENABLE, 32'h1);
    k = 0;
    while (clkrun_oe !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      k = k + 1;
    end
    check("clock run", clkrun_oe, 1'b1);
    k = 0;
    while (!(serirq_oe === 1'b1 && serirq_o === 1'b0) && k < 2000)
    begin
      @(posedge clk);
      k = k + 1;
    end
    check("slave start", serirq_i, 1'b0);
    summarize;
  end
endmodule // tb_top
